//--- design/remote_image_upgrade_control.sv
// remote image upgrade controller: update/control/status registers, watchdog, sequencer, apb slave
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module remote_image_upgrade_control #(
  parameter int osc_div = upgrade_pkg::OSC_DIV,
  parameter int req_cyc = upgrade_pkg::REQ_CYC
) (
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [upgrade_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                      pwdata,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  input  wire logic                             upgrade_shift_clock,
  input  wire logic                             upgrade_serial_in,
  input  wire logic                             shift_or_load_select,
  input  wire logic                             capture_or_commit_select,
  input  wire logic                             fabric_reconfig_request_n,
  input  wire logic                             watchdog_restart_n,
  input  wire logic                             external_reconfig_pin_n,
  input  wire logic                             config_error_line_n,
  input  wire logic                             config_crc_error,
  input  wire logic                             config_done,
  output logic                                  upgrade_serial_out,
  output logic                                  config_start,
  output logic                                  load_application,
  output logic      [upgrade_pkg::PAGE_W-1:0]   image_start_page
);
  if (osc_div < 2 || req_cyc < 1 || req_cyc > 7) begin : g_bad
    $error("unsupported divider or request hold count");
  end

  localparam int SYN_N = 8;
  localparam int OSC_CW = $clog2(osc_div);
  localparam int WR_EN_BIT_L = upgrade_pkg::WR_EN_BIT;
  localparam int WR_ANF_BIT_L = upgrade_pkg::WR_ANF_BIT;
  localparam logic [upgrade_pkg::STAT_W-1:0] STAT_FABRIC_ONLY = 5'h04;
  // ************************************************************
  // pin synchronisers and request filters
  // ************************************************************
  logic [SYN_N-1:0] sync1, sync2, sync3;
  logic [SYN_N-1:0] pins;
  assign pins = {config_error_line_n, external_reconfig_pin_n, watchdog_restart_n, fabric_reconfig_request_n,
                 capture_or_commit_select, shift_or_load_select, upgrade_serial_in, upgrade_shift_clock};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 8'hFF;
      sync2 <= 8'hFF;
      sync3 <= 8'hFF;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  logic shclk_rise, ser_in, shift_sel, capt_sel, ext_fall, errline_low;
  assign shclk_rise  = sync2[0] & ~sync3[0];
  assign ser_in      = sync2[1];
  assign shift_sel   = sync2[2];
  assign capt_sel    = sync2[3];
  assign ext_fall    = ~sync2[6] & sync3[6];
  assign errline_low = ~sync2[7];

  // index 0: fabric request, index 1: watchdog restart
  logic [1:0] req_acc;
  logic [2:0] req_cnt [2];
  for (genvar k = 0; k < 2; k++) begin : g_filt
    logic [2:0] next_cnt;
    always_comb begin
      next_cnt = 3'h0;
      if (!sync2[4+k]) begin
        next_cnt = (req_cnt[k] == 3'(req_cyc)) ? req_cnt[k] : req_cnt[k] + 3'h1;
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        req_cnt[k] <= 3'h0;
      end else begin
        req_cnt[k] <= next_cnt;
      end
    end
    assign req_acc[k] = !sync2[4+k] && req_cnt[k] == 3'(req_cyc - 1);
  end

  // ************************************************************
  // oscillator tick and watchdog
  // ************************************************************
  upgrade_pkg::state_t state, next_state;
  logic [upgrade_pkg::CTRL_W-1:0] ctrl, next_ctrl, upd, next_upd;
  logic [OSC_CW-1:0] osc_cnt, next_osc_cnt;
  logic [upgrade_pkg::WDC_W-1:0] wd_cnt, next_wd_cnt, wd_limit;
  logic osc_tick, watchdog_enable_bit, wd_timeout;
  assign osc_tick = osc_cnt == OSC_CW'(osc_div - 1);
  assign watchdog_enable_bit = state == upgrade_pkg::ST_APP && ctrl[upgrade_pkg::ANF_BIT] && ctrl[upgrade_pkg::WDEN_BIT];
  assign wd_limit = {ctrl[upgrade_pkg::WDT_LSB +: upgrade_pkg::WDT_W], {upgrade_pkg::WDC_ZEROS{1'b0}}};
  assign wd_timeout = watchdog_enable_bit && wd_cnt >= wd_limit;
  always_comb begin
    next_osc_cnt = osc_tick ? '0 : osc_cnt + OSC_CW'(1);
    next_wd_cnt = wd_cnt;
    if (!watchdog_enable_bit || req_acc[1]) begin
      next_wd_cnt = '0;
    end else if (osc_tick && !wd_timeout) begin
      next_wd_cnt = wd_cnt + 29'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_cnt <= '0;
      wd_cnt  <= '0;
    end else begin
      osc_cnt <= next_osc_cnt;
      wd_cnt  <= next_wd_cnt;
    end
  end

  // ************************************************************
  // shift register on the sampled shift clock
  // ************************************************************
  logic [upgrade_pkg::SHIFT_W-1:0] shift_reg, next_shift;
  logic [upgrade_pkg::STAT_W-1:0] status, next_status;
  logic commit;
  assign commit = shclk_rise && !shift_sel && !capt_sel;
  always_comb begin
    next_shift = shift_reg;
    if (shclk_rise && shift_sel) begin
      next_shift = {ser_in, shift_reg[upgrade_pkg::SHIFT_W-1:1]};
    end else if (shclk_rise && capt_sel) begin
      // factory sees the update word, an application its control word
      next_shift = {status, ctrl[upgrade_pkg::ANF_BIT] ? ctrl : upd};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= '0;
    end else begin
      shift_reg <= next_shift;
    end
  end
  assign upgrade_serial_out = shift_reg[0];

  // ************************************************************
  // apb slave
  // ************************************************************
  logic apb_wr, wr_ok, mapped, writable;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  assign apb_wr = psel && penable && pwrite && pready && !pslverr;
  assign wr_ok = !ctrl[upgrade_pkg::ANF_BIT];
  always_comb begin
    mapped = 1'b1;
    writable = 1'b0;
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      upgrade_pkg::A_STATUS:    next_prdata[upgrade_pkg::STAT_W-1:0] = status;
      upgrade_pkg::A_CTRL_PAGE: next_prdata[upgrade_pkg::PAGE_W-1:0] = ctrl[upgrade_pkg::PAGE_LSB +: upgrade_pkg::PAGE_W];
      upgrade_pkg::A_CTRL_WD:   next_prdata[13:0] = {ctrl[upgrade_pkg::ANF_BIT], ctrl[upgrade_pkg::WDEN_BIT],
                                                     ctrl[upgrade_pkg::WDT_LSB +: upgrade_pkg::WDT_W]};
      upgrade_pkg::A_UPD_PAGE: begin
        next_prdata[upgrade_pkg::PAGE_W-1:0] = upd[upgrade_pkg::PAGE_LSB +: upgrade_pkg::PAGE_W];
        writable = wr_ok;
      end
      upgrade_pkg::A_UPD_WD: begin
        next_prdata[13:0] = {upd[upgrade_pkg::ANF_BIT], upd[upgrade_pkg::WDEN_BIT],
                             upd[upgrade_pkg::WDT_LSB +: upgrade_pkg::WDT_W]};
        writable = wr_ok;
      end
      upgrade_pkg::A_STATE:     next_prdata[1:0] = state;
      upgrade_pkg::A_WD_COUNT:  next_prdata[upgrade_pkg::WDC_W-1:0] = wd_cnt;
      default:                  mapped = 1'b0;
    endcase
    next_pready  = psel && !penable;
    next_pslverr = psel && !penable && (!mapped || (pwrite && !writable));
    if (!(psel && !penable && !pwrite)) begin
      next_prdata = 32'h0000_0000;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ************************************************************
  // sequencer
  // ************************************************************
  logic [upgrade_pkg::STAT_W-1:0] cause;
  logic next_start, next_app;
  logic [upgrade_pkg::PAGE_W-1:0] next_page;
  always_comb begin
    next_state  = state;
    next_ctrl   = ctrl;
    next_upd    = upd;
    next_status = status;
    next_start  = 1'b0;
    next_page   = image_start_page;
    next_app    = load_application;
    cause = '0;
    cause[upgrade_pkg::ST_CRC]    = config_crc_error;
    cause[upgrade_pkg::ST_NSTAT]  = errline_low;
    cause[upgrade_pkg::ST_FABRIC] = req_acc[0];
    cause[upgrade_pkg::ST_EXTPIN] = ext_fall;
    cause[upgrade_pkg::ST_WDOG]   = wd_timeout;
    // only the factory image may change the update word
    if (commit && wr_ok) begin
      next_upd = shift_reg[upgrade_pkg::CTRL_W-1:0];
    end
    if (apb_wr && paddr == upgrade_pkg::A_UPD_PAGE) begin
      next_upd[upgrade_pkg::PAGE_LSB +: upgrade_pkg::PAGE_W] = pwdata[upgrade_pkg::PAGE_W-1:0];
    end
    if (apb_wr && paddr == upgrade_pkg::A_UPD_WD) begin
      next_upd[upgrade_pkg::WDT_LSB +: upgrade_pkg::WDT_W] = pwdata[upgrade_pkg::WDT_W-1:0];
      next_upd[upgrade_pkg::WDEN_BIT] = pwdata[WR_EN_BIT_L];
      next_upd[upgrade_pkg::ANF_BIT]  = pwdata[WR_ANF_BIT_L];
    end
    unique case (state)
      upgrade_pkg::ST_LOAD_FACTORY: begin
        if (config_done) begin
          next_state = upgrade_pkg::ST_FACTORY;
        end
      end
      upgrade_pkg::ST_FACTORY: begin
        if (req_acc[0] && !ext_fall) begin
          next_ctrl   = upd;
          next_status = STAT_FABRIC_ONLY;
          next_start  = 1'b1;
          next_page   = upd[upgrade_pkg::PAGE_LSB +: upgrade_pkg::PAGE_W];
          next_app    = upd[upgrade_pkg::ANF_BIT];
          next_state  = upd[upgrade_pkg::ANF_BIT] ? upgrade_pkg::ST_LOAD_APP : upgrade_pkg::ST_LOAD_FACTORY;
        end
      end
      upgrade_pkg::ST_LOAD_APP: begin
        if (config_done && !config_crc_error && !errline_low) begin
          next_state = upgrade_pkg::ST_APP;
        end
      end
      upgrade_pkg::ST_APP: begin
      end
    endcase
    // fallback to factory image
    if (ext_fall || ((state == upgrade_pkg::ST_LOAD_FACTORY || state == upgrade_pkg::ST_LOAD_APP)
                     && (config_crc_error || errline_low))
        || (state == upgrade_pkg::ST_APP && cause != '0)) begin
      next_ctrl   = upgrade_pkg::CTRL_RESET;
      next_upd    = upgrade_pkg::CTRL_RESET;
      next_status = cause;
      next_start  = 1'b1;
      next_page   = upgrade_pkg::FACTORY_PAGE;
      next_app    = 1'b0;
      next_state  = upgrade_pkg::ST_LOAD_FACTORY;
    end
  end
  // registers, watchdog and this sequencer form the controller
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state            <= upgrade_pkg::ST_LOAD_FACTORY;
      ctrl             <= upgrade_pkg::CTRL_RESET;
      upd              <= upgrade_pkg::CTRL_RESET;
      status           <= upgrade_pkg::STAT_RESET;
      config_start     <= 1'b0;
      image_start_page <= upgrade_pkg::FACTORY_PAGE;
      load_application <= 1'b0;
    end else begin
      state            <= next_state;
      ctrl             <= next_ctrl;
      upd              <= next_upd;
      status           <= next_status;
      config_start     <= next_start;
      image_start_page <= next_page;
      load_application <= next_app;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  sequence req_hold_s;
    sync3[4] && !sync2[4] ##1 !sync2[4] [*4];
  endsequence
  sequence fallback_s;
    config_start && !load_application ##0 image_start_page == 24'h00_0000;
  endsequence
  factory_page_a: assert property (@(posedge pclk) disable iff (!presetn)
    (config_start && !load_application) |-> fallback_s) else $error("factory load not from page zero");
  anf_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (config_start && !load_application) |-> !ctrl[0] && upd == 38'h00_0000_0000) else $error("flag not cleared");
  ext_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    ext_fall |=> fallback_s and status[3] && state == upgrade_pkg::ST_LOAD_FACTORY) else $error("pin fallback");
  app_crc_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == upgrade_pkg::ST_APP && config_crc_error) |=> status[0] && config_start) else $error("crc fallback");
  commit_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == upgrade_pkg::ST_FACTORY && req_acc[0] && !ext_fall) |=> ctrl == $past(upd) && config_start
    && image_start_page == $past(upd[24:1])) else $error("update not copied");
  wd_fire_a: assert property (@(posedge pclk) disable iff (!presetn)
    (watchdog_enable_bit && wd_cnt >= {ctrl[37:26], 17'h0_0000}) |=> status[4] && state == upgrade_pkg::ST_LOAD_FACTORY)
    else $error("watchdog did not fire");
  req_filter_a: assert property (@(posedge pclk) disable iff (!presetn)
    req_hold_s |-> req_acc[0]) else $error("held request not accepted");
  load_error_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == upgrade_pkg::ST_LOAD_APP && errline_low && !config_crc_error && !ext_fall && !req_acc[0])
    |=> status == 5'h02 && config_start && !load_application && state == upgrade_pkg::ST_LOAD_FACTORY)
    else $error("load error not reverted");
  wd_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
    req_acc[1] |=> wd_cnt == '0) else $error("watchdog not restarted");
  shift_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    (shclk_rise && shift_sel) |=> upgrade_serial_out == $past(shift_reg[1])) else $error("shift broken");
endmodule // remote_image_upgrade_control
`default_nettype wire

//--- design/upgrade_pkg.sv
// constants and types shared by the remote image upgrade controller
package upgrade_pkg;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ        = 20_000_000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int OSC_HZ        = 10_000_000;
  localparam int OSC_DIV       = CLK_HZ / OSC_HZ;
  localparam int REQ_MIN_NS    = 250;
  localparam int REQ_CYC       = (REQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ************************************************************
  // control / update word layout
  // ************************************************************
  localparam int CTRL_W    = 38;
  localparam int ANF_BIT   = 0;
  localparam int PAGE_LSB  = 1;
  localparam int PAGE_W    = 24;
  localparam int WDEN_BIT  = 25;
  localparam int WDT_LSB   = 26;
  localparam int WDT_W     = 12;
  localparam int WDC_W     = 29;
  localparam int WDC_ZEROS = 17;
  localparam logic [CTRL_W-1:0] CTRL_RESET   = 38'h00_0000_0000;
  localparam logic [PAGE_W-1:0] FACTORY_PAGE = 24'h00_0000;
  // ************************************************************
  // status word layout
  // ************************************************************
  localparam int STAT_W    = 5;
  localparam int ST_CRC    = 0;
  localparam int ST_NSTAT  = 1;
  localparam int ST_FABRIC = 2;
  localparam int ST_EXTPIN = 3;
  localparam int ST_WDOG   = 4;
  localparam logic [STAT_W-1:0] STAT_RESET = 5'h00;
  localparam int SHIFT_W   = STAT_W + CTRL_W;
  // ************************************************************
  // apb map
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] A_STATUS    = 8'h00;
  localparam logic [ADDR_W-1:0] A_CTRL_PAGE = 8'h04;
  localparam logic [ADDR_W-1:0] A_CTRL_WD   = 8'h08;
  localparam logic [ADDR_W-1:0] A_UPD_PAGE  = 8'h0C;
  localparam logic [ADDR_W-1:0] A_UPD_WD    = 8'h10;
  localparam logic [ADDR_W-1:0] A_STATE     = 8'h14;
  localparam logic [ADDR_W-1:0] A_WD_COUNT  = 8'h18;
  // wd word: timer in [11:0], enable [12], anf [13]
  localparam int WR_EN_BIT  = 12;
  localparam int WR_ANF_BIT = 13;
  typedef enum logic [1:0] {
    ST_LOAD_FACTORY = 2'b00,
    ST_FACTORY      = 2'b01,
    ST_LOAD_APP     = 2'b10,
    ST_APP          = 2'b11
  } state_t;
endpackage

//--- testbench/fabric_model.sv
// fabric-side model: shift link frames and reconfiguration request
`timescale 1ns/1ns
`default_nettype none
module fabric_model (
  input  wire logic pclk,
  input  wire logic upgrade_serial_out,
  output logic      upgrade_shift_clock,
  output logic      upgrade_serial_in,
  output logic      shift_or_load_select,
  output logic      capture_or_commit_select,
  output logic      fabric_reconfig_request_n,
  output logic      watchdog_restart_n
);
  // ************************************************************
  // link driver
  // ************************************************************
  initial begin
    upgrade_shift_clock = 1'b0;
    upgrade_serial_in = 1'b0;
    shift_or_load_select = 1'b1;
    capture_or_commit_select = 1'b1;
    fabric_reconfig_request_n = 1'b1;
    watchdog_restart_n = 1'b1;
  end
  // one 400 ns link period, clock stands low between frames
  task automatic tick();
    #200 upgrade_shift_clock = 1'b1;
    #200 upgrade_shift_clock = 1'b0;
  endtask
  // capture, shift 43 bits lsb first, then commit
  task automatic frame(input logic [42:0] din, output logic [42:0] dout);
    #13 shift_or_load_select = 1'b0;
    capture_or_commit_select = 1'b1;
    tick();
    shift_or_load_select = 1'b1;
    for (int i = 0; i < 43; i++) begin
      upgrade_serial_in = din[i];
      #200 dout[i] = upgrade_serial_out;
      upgrade_shift_clock = 1'b1;
      #200 upgrade_shift_clock = 1'b0;
    end
    shift_or_load_select = 1'b0;
    capture_or_commit_select = 1'b0;
    tick();
    upgrade_serial_in = ~upgrade_serial_in;
    capture_or_commit_select = 1'b1;
  endtask
  // request held 10 pclk cycles, beyond the 250 ns minimum
  task automatic request();
    @(posedge pclk);
    fabric_reconfig_request_n <= 1'b0;
    repeat (10) @(posedge pclk);
    fabric_reconfig_request_n <= 1'b1;
  endtask
  // watchdog restart held 10 pclk cycles
  task automatic restart();
    @(posedge pclk);
    watchdog_restart_n <= 1'b0;
    repeat (10) @(posedge pclk);
    watchdog_restart_n <= 1'b1;
  endtask
endmodule // fabric_model
`default_nettype wire

//--- testbench/tb_top.sv
// testbench for the remote image upgrade controller
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ************************************************************
  // signals and design
  // ************************************************************
  logic                           pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [upgrade_pkg::ADDR_W-1:0] paddr;
  logic [31:0]                    pwdata, prdata, q;
  logic                           sclk, sin, sout, ssel, csel, req_n, wdr_n;
  logic                           pin_n, err_n, crc, done, cstart, app;
  logic [23:0]                    page;
  logic [42:0]                    dout;
  int                             n_fail, n_compared;
  typedef struct {logic [23:0] pg; logic [31:0] wd; int cause; logic [4:0] st;} row_t;
  row_t rows [5] = '{'{24'h00_0100, 32'h0000_2000, 0, 5'h01}, '{24'h01_0000, 32'h0000_2FFF, 1, 5'h02},
                     '{24'hFF_FF00, 32'h0000_2000, 2, 5'h04}, '{24'h00_0200, 32'h0000_2000, 3, 5'h08},
                     '{24'h00_0300, 32'h0000_3000, 4, 5'h10}};
  remote_image_upgrade_control dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .upgrade_shift_clock(sclk), .upgrade_serial_in(sin), .shift_or_load_select(ssel),
    .capture_or_commit_select(csel), .fabric_reconfig_request_n(req_n),
    .watchdog_restart_n(wdr_n), .external_reconfig_pin_n(pin_n), .config_error_line_n(err_n),
    .config_crc_error(crc), .config_done(done), .upgrade_serial_out(sout),
    .config_start(cstart), .load_application(app), .image_start_page(page));
  fabric_model u_fab (.pclk(pclk), .upgrade_serial_out(sout), .upgrade_shift_clock(sclk),
    .upgrade_serial_in(sin), .shift_or_load_select(ssel), .capture_or_commit_select(csel),
    .fabric_reconfig_request_n(req_n), .watchdog_restart_n(wdr_n));
  // ************************************************************
  // tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // apb transfer; read data and error land in q and e
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) n_fail++;
  endtask
  task automatic finish_load();
    @(posedge pclk);
    done <= 1'b1;
    @(posedge pclk);
    done <= 1'b0;
  endtask
  task automatic launch(input logic [23:0] pg, input logic [31:0] wd);
    int k;
    apb(1'b1, upgrade_pkg::A_UPD_PAGE, {8'h00, pg});
    apb(1'b1, upgrade_pkg::A_UPD_WD, wd);
    k = 0;
    fork
      u_fab.request();
      do @(posedge pclk); while (cstart !== 1'b1 && ++k < 100);
    join
    if (k >= 100) n_fail++;
    chk(page, pg);
    chk(app, 1'b1);
    finish_load();
  endtask
  task automatic results();
    if (n_fail == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ************************************************************
  // sequence
  // ************************************************************
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    #1_000_000;
    n_fail++;
    results();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {pin_n, err_n, crc, done} = 4'b1100;
    cyc(4);
    presetn <= 1'b1;
    chk(page, 24'h0);
    chk(app, 1'b0);
    apb(1'b0, upgrade_pkg::A_STATUS, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, upgrade_pkg::A_STATE, 32'h0);
    chk(q, {30'h0, upgrade_pkg::ST_LOAD_FACTORY});
    for (int i = 0; i < 5; i++) begin
      finish_load();
      launch(rows[i].pg, rows[i].wd);
      if (rows[i].cause != 4) begin
        apb(1'b0, upgrade_pkg::A_STATE, 32'h0);
        chk(q, {30'h0, upgrade_pkg::ST_APP});
      end
      case (rows[i].cause)
        0: begin @(posedge pclk); crc <= 1'b1; @(posedge pclk); crc <= 1'b0; end
        1: begin @(posedge pclk); err_n <= 1'b0; cyc(8); err_n <= 1'b1; end
        2: u_fab.request();
        3: begin @(posedge pclk); pin_n <= 1'b0; cyc(8); pin_n <= 1'b1; end
        default: ;
      endcase
      for (int k = 0; k < 200 && app !== 1'b0; k++) @(posedge pclk);
      cyc(8);
      chk(page, 24'h0);
      chk(app, 1'b0);
      apb(1'b0, upgrade_pkg::A_STATUS, 32'h0);
      chk(q, rows[i].st);
      apb(1'b0, upgrade_pkg::A_CTRL_WD, 32'h0);
      chk(q, 32'h0);
    end
    finish_load();
    apb(1'b0, 8'h1C, 32'h0);
    chk(e, 1'b1);
    apb(1'b1, upgrade_pkg::A_STATUS, 32'h1F);
    chk(e, 1'b1);
    u_fab.frame({5'h00, 12'h000, 1'b0, 24'h00_ABCD, 1'b1}, dout);
    chk(dout[42:38], 5'h10);
    chk(dout[31:0], 32'h0);
    apb(1'b0, upgrade_pkg::A_UPD_PAGE, 32'h0);
    chk(q, 32'h0000_ABCD);
    apb(1'b0, upgrade_pkg::A_UPD_WD, 32'h0);
    chk(q, 32'h0000_2000);
    launch(24'h00_ABCD, 32'h0000_3001);
    apb(1'b1, upgrade_pkg::A_UPD_PAGE, 32'h0);
    chk(e, 1'b1);
    // watchdog runs in the application and a restart clears it
    cyc(40);
    apb(1'b0, upgrade_pkg::A_WD_COUNT, 32'h0);
    chk(q >= 32'h0000_0010, 1'b1);
    u_fab.restart();
    apb(1'b0, upgrade_pkg::A_WD_COUNT, 32'h0);
    chk(q < 32'h0000_0010, 1'b1);
    // back to factory, then an error line during the application load
    @(posedge pclk);
    pin_n <= 1'b0;
    cyc(8);
    pin_n <= 1'b1;
    cyc(8);
    finish_load();
    apb(1'b1, upgrade_pkg::A_UPD_PAGE, 32'h0000_0400);
    apb(1'b1, upgrade_pkg::A_UPD_WD, 32'h0000_2000);
    u_fab.request();
    @(posedge pclk);
    err_n <= 1'b0;
    cyc(8);
    err_n <= 1'b1;
    cyc(8);
    chk(app, 1'b0);
    chk(page, 24'h0);
    apb(1'b0, upgrade_pkg::A_STATUS, 32'h0);
    chk(q, 32'h0000_0002);
    @(posedge pclk);
    presetn <= 1'b0;
    cyc(2);
    chk(app, 1'b0);
    chk(page, 24'h0);
    presetn <= 1'b1;
    apb(1'b0, upgrade_pkg::A_STATUS, 32'h0);
    chk(q, 32'h0);
    results();
  end
endmodule // tb_top
`default_nettype wire
